/* File: dv/aosl_core_checker.sv */
// Assertions on the ports of the offset and sleep link core.
// Assumes one clock with a synchronous active-high reset.
module aosl_core_checker #(
  parameter int SW = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire logic improvedTap,
  input wire logic linkEn,
  input wire logic autoSleepEn,
  input wire logic sleepEn,
  input wire logic actDetect,
  input wire logic inactDetect,
  input wire logic tapDetect,
  input wire logic detValid,
  input wire logic [SW-1:0] detX,
  input wire logic [2:0] tapSignNeg,
  input wire logic actArmed,
  input wire logic inactArmed,
  input wire logic actPending,
  input wire logic inactPending,
  input wire logic asleep
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire allOn = linkEn && sleepEn && autoSleepEn;
  sequence rdOf(a);
    regSel && !regWr && regAddr == a;
  endsequence
  sequence dozed;
    asleep && actArmed && !inactArmed;
  endsequence
  sequence woken;
    !asleep && actPending && !actArmed && inactArmed;
  endsequence
  cause_clear_a: assert property (rdOf(8'h30) ##0 (!actDetect
    && !inactDetect) |=> !actPending && !inactPending) else $error("kept");
  sleep_entry_a: assert property (allOn && inactDetect && inactArmed
    && !actPending && !actDetect |=> dozed) else $error("no sleep");
  sleep_block_a: assert property (!asleep && actPending |=> !asleep)
    else $error("slept with activity pending");
  wake_up_a: assert property (asleep && actDetect && actArmed |=> woken)
    else $error("no wake");
  link_arm_a: assert property (linkEn && !actArmed && !inactDetect
    |=> !actArmed || !linkEn) else $error("activity armed early");
  asleep_bit_a: assert property (rdOf(8'h2B)
    |=> regRdData[3] == $past(asleep)) else $error("asleep bit wrong");
  det_feed_a: assert property (!improvedTap
    |=> detValid == $past(sampleValid)) else $error("detector feed wrong");
  tap_sign_a: assert property (tapDetect
    |=> tapSignNeg[0] == $past(detX[SW-1])) else $error("tap sign wrong");
endmodule
bind aosl_core aosl_core_checker #(.SW(SW)) chk_u (.sys_clk, .rst, .regSel,
  .regWr, .regAddr, .regRdData, .sampleValid, .improvedTap, .linkEn,
  .autoSleepEn, .sleepEn, .actDetect, .inactDetect, .tapDetect, .detValid,
  .detX, .tapSignNeg, .actArmed, .inactArmed, .actPending, .inactPending,
  .asleep);

/* File: dv/aosl_host.sv */
// Host model: drives the register port and queues what each read should return.
// Assumes requests move on the falling clock edge.
module aosl_host (
  input wire logic sys_clk,
  output logic regSel,
  output logic regWr,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  initial begin
    regSel = 1'b0;
    regWr = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regSel = 1'b1;
    regWr = w;
    regAddr = a;
    regWrData = d;
    @(negedge sys_clk);
    regSel = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    acc(1'b0, a, 8'h00);
  endtask
endmodule

/* File: dv/tb.sv */
// Testbench of the offset and sleep link core with a host model.
// Assumes read data one cycle after the request.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst = 1'b1, sampleValid = 1'b0, fullRes = 1'b1;
  logic improvedTap = 1'b0, linkEn = 1'b1, autoSleepEn = 1'b0, sleepEn = 1'b0;
  logic actDetect = 1'b0, inactDetect = 1'b0, tapDetect = 1'b0, rdLate = 1'b0;
  logic [1:0] rangeSel = 2'h3;
  logic [3:0] rateShift = 4'h0;
  logic [2:0] actAxesIn = 3'h0, tapAxesIn = 3'h0, tapSignNeg;
  logic [15:0] sampleX = 16'h0, sampleY = 16'h0, sampleZ = 16'h0;
  logic [15:0] detX, detY, detZ;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regSel, regWr, detValid, actArmed, inactArmed, actPending;
  logic inactPending, dataReady, asleep;
  logic [47:0] lastE, outE;
  logic [47:0] detQ[$];
  int errCount = 0, checksDone = 0;
  always #12.5 sys_clk = ~sys_clk;
  aosl_host host_u (.sys_clk, .regSel, .regWr, .regAddr, .regWrData);
  aosl_core #(.SW(16)) dut_u (.sys_clk, .rst, .regSel, .regWr, .regAddr,
    .regWrData, .regRdData, .sampleValid, .sampleX, .sampleY, .sampleZ,
    .rateShift, .fullRes, .rangeSel, .improvedTap, .linkEn, .autoSleepEn,
    .sleepEn, .actDetect, .actAxesIn, .inactDetect, .tapDetect, .tapAxesIn,
    .detValid, .detX, .detY, .detZ, .tapSignNeg, .actArmed, .inactArmed,
    .actPending, .inactPending, .dataReady, .asleep);
  task automatic cmp(input logic [47:0] g, input logic [47:0] e);
    checksDone++;
    if (g !== e) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic pulse(ref logic p);
    @(negedge sys_clk);
    p = 1'b1;
    @(negedge sys_clk);
    p = 1'b0;
  endtask
  function automatic logic [15:0] trimOf(input logic [7:0] t);
    logic signed [17:0] e;
    e = {{8{t[7]}}, t, 2'b00};
    if (!fullRes) e = e >>> rangeSel;
    return e[15:0];
  endfunction
  task automatic smp(input logic [15:0] s[3], input logic [7:0] t[3],
                     input bit det);
    for (int i = 0; i < 3; i++)
      lastE[47-16*i -: 16] = s[i] + trimOf(t[i]);
    if (det) begin
      detQ.push_back(lastE);
      outE = lastE;
    end
    @(negedge sys_clk);
    sampleValid = 1'b1;
    {sampleX, sampleY, sampleZ} = {s[0], s[1], s[2]};
    @(negedge sys_clk);
    sampleValid = 1'b0;
    {sampleX, sampleY, sampleZ} = ~{s[0], s[1], s[2]};
  endtask
  always @(posedge sys_clk) rdLate <= regSel && !regWr && !rst;
  always @(negedge sys_clk) begin
    if (rdLate)
      cmp(regRdData & host_u.mskQ.pop_front(), host_u.expQ.pop_front());
    if (detValid === 1'b1) cmp({detX, detY, detZ}, detQ.pop_front());
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errCount++;
    give_verdict();
  end
  initial begin
    logic [15:0] s[3];
    logic [7:0] t[3];
    void'($urandom(62));
    s = '{16'd10, -16'sd13, 16'd9};
    t = '{8'hFD, 8'h03, 8'hFE};
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) host_u.rd(8'h1E + 8'(i), 8'h00, 8'hFF);
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 3; i++) host_u.acc(1'b1, 8'h1E + 8'(i), t[i]);
      smp(s, t, 1'b1);
      tapAxesIn = 3'($urandom);
      pulse(tapDetect);
      cmp(tapSignNeg, {lastE[15], lastE[31], lastE[47]});
      for (int i = 0; i < 3; i++) begin
        t[i] = 8'($urandom);
        s[i] = 16'($urandom_range(4000)) - 16'd2000;
      end
    end
    fullRes = 1'b0;
    for (int r = 0; r < 4; r++) begin
      rangeSel = 2'(r);
      for (int i = 0; i < 3; i++) begin
        t[i] = 8'($urandom);
        host_u.acc(1'b1, 8'h1E + 8'(i), t[i]);
      end
      smp(s, t, 1'b1);
    end
    host_u.rd(8'h30, 8'h80, 8'h80);
    improvedTap = 1'b1;
    rateShift = 4'h2;
    for (int k = 0; k < 7; k++) begin
      s[0] = 16'($urandom_range(4000)) - 16'd2000;
      smp(s, t, k == 3);
      cmp(dataReady, 48'(k >= 3));
    end
    host_u.acc(1'b1, 8'h32, 8'hA5);
    for (int n = 0; n < 6; n++)
      host_u.rd(8'h32 + 8'(n), outE[39-16*(n/2)+8*(n%2) -: 8], 8'hFF);
    host_u.rd(8'h21, 8'h00, 8'hFF);
    host_u.rd(8'h30, 8'h80, 8'h98);
    sleepEn = 1'b1;
    autoSleepEn = 1'b1;
    pulse(inactDetect);
    host_u.rd(8'h2B, 8'h08 | 8'(tapAxesIn), 8'h7F);
    host_u.rd(8'h30, 8'h08, 8'h18);
    actAxesIn = 3'h5;
    pulse(actDetect);
    host_u.rd(8'h2B, 8'h50, 8'h78);
    pulse(inactDetect);
    host_u.rd(8'h2B, 8'h50, 8'h78);
    host_u.rd(8'h30, 8'h10, 8'h10);
    host_u.rd(8'h30, 8'h00, 8'h18);
    linkEn = 1'b0;
    actAxesIn = 3'h2;
    pulse(actDetect);
    host_u.rd(8'h2B, 8'h20, 8'h78);
    host_u.rd(8'h30, 8'h10, 8'h10);
    repeat (3) @(negedge sys_clk);
    cmp(48'(detQ.size() + host_u.expQ.size()), 48'h0);
    give_verdict();
  end
endmodule

/* File: rtl/aosl_core.sv */
// Offset trim, decimation, link and automatic sleep of the accelerometer.
// Assumes samples arrive at the internal rate in the selected output format
// and that event detectors sit outside, fed from the detector sample port.
`include "aosl_regs.svh"
module aosl_core #(
  parameter int SW = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire logic [SW-1:0] sampleX,
  input wire logic [SW-1:0] sampleY,
  input wire logic [SW-1:0] sampleZ,
  input wire logic [3:0] rateShift,
  input wire logic fullRes,
  input wire logic [1:0] rangeSel,
  input wire logic improvedTap,
  input wire logic linkEn,
  input wire logic autoSleepEn,
  input wire logic sleepEn,
  input wire logic actDetect,
  input wire logic [2:0] actAxesIn,
  input wire logic inactDetect,
  input wire logic tapDetect,
  input wire logic [2:0] tapAxesIn,
  output logic detValid,
  output logic [SW-1:0] detX,
  output logic [SW-1:0] detY,
  output logic [SW-1:0] detZ,
  output logic [2:0] tapSignNeg,
  output logic actArmed,
  output logic inactArmed,
  output logic actPending,
  output logic inactPending,
  output logic dataReady,
  output logic asleep
);
  logic [SW-1:0] smp [3];
  logic [SW-1:0] comp [3];
  logic [7:0] ofs_r [3];
  logic [7:0] ofs_nxt [3];
  logic [SW-1:0] data_r [3];
  logic [SW-1:0] data_nxt [3];
  logic [SW-1:0] det_r [3];
  logic [SW-1:0] det_nxt [3];
  logic detValid_r, detValid_nxt;
  logic [15:0] decCnt_r, decCnt_nxt;
  logic [15:0] decLimit;
  logic [3:0] curShift;
  logic outStrobe;
  logic [7:0] rdData_r, rdData_nxt;
  logic rdCause, actEv, inactEv;
  logic actPend_r, actPend_nxt;
  logic inactPend_r, inactPend_nxt;
  logic rdy_r, rdy_nxt;
  logic actArm_r, actArm_nxt;
  logic inactArm_r, inactArm_nxt;
  logic [2:0] actAxes_r, actAxes_nxt;
  logic [2:0] tapAxes_r, tapAxes_nxt;
  logic [2:0] tapSign_r, tapSign_nxt;
  aosl_pkg::aosl_sleep_t sleep_r, sleep_nxt;

  assign smp[0] = sampleX;
  assign smp[1] = sampleY;
  assign smp[2] = sampleZ;

  // The trim LSB is fixed in g, so its weight in output LSBs follows the
  // output format; at the widest fixed range it halves and loses its LSB.
  function automatic logic [SW-1:0] scaleOfs(input logic [7:0] o,
                                             input logic fr,
                                             input logic [1:0] rg);
    logic [SW-1:0] e;
    e = {{(SW-8){o[7]}}, o};
    if (fr) begin
      scaleOfs = e << 2; // R11 R12
    end else begin
      unique case (rg)
        2'h0: scaleOfs = e << 2; // R16
        2'h1: scaleOfs = e << 1; // R16
        2'h2: scaleOfs = e; // R16
        2'h3: scaleOfs = {e[SW-1], e[SW-1:1]}; // R16
      endcase
    end
  endfunction

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      // Two's complement sum, so a negative trim lowers the result.
      assign comp[a] = smp[a] + scaleOfs(ofs_r[a], fullRes, rangeSel); // R10 R14
    end
  endgenerate

  // Decimation of the one internal stream into the output rate.
  always_comb begin
    curShift = (sleep_r == aosl_pkg::AOSL_ASLEEP) ?
               `AOSL_SLEEP_SHIFT : rateShift; // R8 R9
    decLimit = 16'((17'h00001 << curShift) - 17'h00001);
    decCnt_nxt = decCnt_r;
    outStrobe = 1'b0;
    if (sampleValid) begin
      if (decCnt_r >= decLimit) begin
        decCnt_nxt = 16'h0000;
        outStrobe = 1'b1; // R2
      end else begin
        decCnt_nxt = decCnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      decCnt_r <= 16'h0000;
    end else begin
      decCnt_r <= decCnt_nxt;
    end
  end

  // Data path: output words, detector feed and the offset trims.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ofs_nxt[i] = ofs_r[i];
      data_nxt[i] = outStrobe ? comp[i] : data_r[i]; // R10
      det_nxt[i] = det_r[i];
    end
    // Detectors see every sample unless improved tap asks for output data.
    detValid_nxt = improvedTap ? outStrobe : sampleValid; // R2
    if (detValid_nxt) begin
      for (int i = 0; i < 3; i++) begin
        det_nxt[i] = comp[i];
      end
    end
    if (regSel && regWr) begin
      if (regAddr == `AOSL_ADDR_X_OFS) begin
        ofs_nxt[0] = regWrData;
      end
      if (regAddr == `AOSL_ADDR_Y_OFS) begin
        ofs_nxt[1] = regWrData;
      end
      if (regAddr == `AOSL_ADDR_Z_OFS) begin
        ofs_nxt[2] = regWrData;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ofs_r[i] <= `AOSL_OFS_RESET; // R13
        data_r[i] <= '0;
        det_r[i] <= '0;
      end
      detValid_r <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ofs_r[i] <= ofs_nxt[i];
        data_r[i] <= data_nxt[i];
        det_r[i] <= det_nxt[i];
      end
      detValid_r <= detValid_nxt;
    end
  end

  // Events, link arming, sleep state and the motion status fields.
  always_comb begin
    rdCause = regSel && !regWr && (regAddr == `AOSL_ADDR_CAUSE);
    actEv = actDetect && actArm_r;
    inactEv = inactDetect && inactArm_r;
    actPend_nxt = actPend_r;
    inactPend_nxt = inactPend_r;
    rdy_nxt = rdy_r;
    actArm_nxt = actArm_r;
    inactArm_nxt = inactArm_r;
    actAxes_nxt = actAxes_r;
    tapAxes_nxt = tapAxes_r;
    tapSign_nxt = tapSign_r;
    sleep_nxt = sleep_r;
    if (rdCause) begin
      actPend_nxt = 1'b0; // R4
      inactPend_nxt = 1'b0; // R4
      rdy_nxt = 1'b0;
    end
    // A new event in the clearing cycle still lands.
    if (actEv) begin
      actPend_nxt = 1'b1;
    end
    if (inactEv) begin
      inactPend_nxt = 1'b1;
    end
    // Sleep only swaps rateShift for the fixed sleep shift; data-ready follows every output word.
    if (outStrobe) begin
      rdy_nxt = 1'b1; // R7
    end
    if (!linkEn) begin
      actArm_nxt = 1'b1;
      inactArm_nxt = 1'b1;
    end else if (inactEv) begin
      actArm_nxt = 1'b1; // R3 R8
      inactArm_nxt = 1'b0; // R8
    end else if (actEv) begin
      actArm_nxt = 1'b0; // R9
      inactArm_nxt = 1'b1; // R9
    end
    unique case (sleep_r)
      aosl_pkg::AOSL_AWAKE: begin
        if (sleepEn && autoSleepEn && linkEn && inactEv && !actPend_r) begin
          sleep_nxt = aosl_pkg::AOSL_ASLEEP; // R5 R8
        end
      end
      aosl_pkg::AOSL_ASLEEP: begin
        if (actEv || !sleepEn) begin
          sleep_nxt = aosl_pkg::AOSL_AWAKE; // R9
        end
      end
    endcase
    // Status fields are only overwritten by new events, never cleared.
    if (actEv) begin
      actAxes_nxt = actAxesIn; // R15
    end
    if (tapDetect) begin
      tapAxes_nxt = tapAxesIn; // R15
      // A strike on the positive face is a negative acceleration.
      tapSign_nxt = {det_r[2][SW-1], det_r[1][SW-1], det_r[0][SW-1]}; // R1
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      actPend_r <= 1'b0;
      inactPend_r <= 1'b0;
      rdy_r <= 1'b0;
      actArm_r <= 1'b0;
      inactArm_r <= 1'b1;
      actAxes_r <= 3'h0;
      tapAxes_r <= 3'h0;
      tapSign_r <= 3'h0;
      sleep_r <= aosl_pkg::AOSL_AWAKE;
    end else begin
      actPend_r <= actPend_nxt;
      inactPend_r <= inactPend_nxt;
      rdy_r <= rdy_nxt;
      actArm_r <= actArm_nxt;
      inactArm_r <= inactArm_nxt;
      actAxes_r <= actAxes_nxt;
      tapAxes_r <= tapAxes_nxt;
      tapSign_r <= tapSign_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // Register read path, answered one cycle after the request.
  always_comb begin
    rdData_nxt = 8'h00;
    if (regSel && !regWr) begin
      if (regAddr == `AOSL_ADDR_X_OFS) begin
        rdData_nxt = ofs_r[0];
      end else if (regAddr == `AOSL_ADDR_Y_OFS) begin
        rdData_nxt = ofs_r[1];
      end else if (regAddr == `AOSL_ADDR_Z_OFS) begin
        rdData_nxt = ofs_r[2];
      end else if (regAddr == `AOSL_ADDR_MOTION) begin
        rdData_nxt[`AOSL_MOT_ACT_LSB +: 3] = actAxes_r;
        rdData_nxt[`AOSL_MOT_ASLEEP] =
          (sleep_r == aosl_pkg::AOSL_ASLEEP); // R6
        rdData_nxt[`AOSL_MOT_TAP_LSB +: 3] = tapAxes_r;
      end else if (regAddr == `AOSL_ADDR_CAUSE) begin
        rdData_nxt[`AOSL_CAUSE_RDY] = rdy_r;
        rdData_nxt[`AOSL_CAUSE_ACT] = actPend_r;
        rdData_nxt[`AOSL_CAUSE_INACT] = inactPend_r;
      end else if (regAddr >= `AOSL_ADDR_DATA0 &&
                   regAddr <= `AOSL_ADDR_DATA5) begin
        unique case (3'(regAddr - `AOSL_ADDR_DATA0))
          3'h0: rdData_nxt = data_r[0][7:0];
          3'h1: rdData_nxt = data_r[0][15:8];
          3'h2: rdData_nxt = data_r[1][7:0];
          3'h3: rdData_nxt = data_r[1][15:8];
          3'h4: rdData_nxt = data_r[2][7:0];
          3'h5: rdData_nxt = data_r[2][15:8];
          default: rdData_nxt = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign detValid = detValid_r;
  assign detX = det_r[0];
  assign detY = det_r[1];
  assign detZ = det_r[2];
  assign tapSignNeg = tapSign_r;
  assign actArmed = actArm_r;
  assign inactArmed = inactArm_r;
  assign actPending = actPend_r;
  assign inactPending = inactPend_r;
  assign dataReady = rdy_r;
  assign asleep = (sleep_r == aosl_pkg::AOSL_ASLEEP);
endmodule

/* File: rtl/aosl_pkg.sv */
// Types of the offset and sleep link block.
// Assumes nothing beyond the register header.
package aosl_pkg;
  typedef enum logic {AOSL_AWAKE, AOSL_ASLEEP} aosl_sleep_t;
endpackage

/* File: rtl/aosl_regs.svh */
// Register offsets, field positions, reset values and rates of the offset
// and sleep link block. Assumes the byte-wide register port of the device.
// What this block does
// (R1) A tap on an axis's positive face is reported with a negative sign.
// (R2) Output rates come from decimating one sample stream, detectors only when improved tap is set.
// (R3) With link on, activity is armed only after inactivity was detected.
// (R4) Reading the cause register at 0x30 clears the pending events.
// (R5) Automatic sleep is refused while an activity event is uncleared.
// (R6) The asleep bit of the motion event status register shows sleep.
// (R7) Low power keeps data-ready and data output fully working.
// (R8) With sleep, autosleep and link on, inactivity drops to the sleep rate.
// (R9) Activity while asleep restores the rate and swaps the detector arming.
// (R10) Each axis's signed offset trim is added to every sample.
// (R11) An offset trim LSB weighs 15.6 mg whatever the range.
// (R12) In full resolution one trim LSB is four output LSBs.
// (R13) Offset trims return to zero at reset.
// (R14) The trim is purely additive, negative lowers, positive raises.
// (R15) The motion event status register is only ever overwritten.
// (R16) In fixed 10-bit modes the trim is scaled to the range's output LSB.
`ifndef AOSL_REGS_SVH
`define AOSL_REGS_SVH
`define AOSL_ADDR_X_OFS 8'h1E
`define AOSL_ADDR_Y_OFS 8'h1F
`define AOSL_ADDR_Z_OFS 8'h20
`define AOSL_ADDR_MOTION 8'h2B
`define AOSL_ADDR_CAUSE 8'h30
`define AOSL_ADDR_DATA0 8'h32
`define AOSL_ADDR_DATA5 8'h37
`define AOSL_OFS_RESET 8'h00
`define AOSL_CAUSE_RDY 7
`define AOSL_CAUSE_ACT 4
`define AOSL_CAUSE_INACT 3
`define AOSL_MOT_ACT_LSB 4
`define AOSL_MOT_ASLEEP 3
`define AOSL_MOT_TAP_LSB 0
`define AOSL_SLEEP_SHIFT 4'h7
`endif
